// ### rsp_pkg.sv
// Purpose : Shared constants and types of the clock/RAM serial slave port.
// Assumes : Byte-wide link, 128-entry clock and RAM space behind the port.
// Notes   : Addresses carry the direction in their top bit.

package rsp_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned IDX_W      = 7;
  localparam int unsigned CNT_W      = 3;
  localparam int unsigned MEM_DEPTH  = 128;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned DIR_BIT    = 7;
  localparam int unsigned LOCK_BIT   = 6;

  // ------------------------------------------------------------------
  // Address map and pointer wrap points (index part, direction stripped)
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0]  CLK_TOP_IDX  = 7'h1f;
  localparam logic [IDX_W-1:0]  CLK_BASE_IDX = 7'h00;
  localparam logic [IDX_W-1:0]  RAM_TOP_IDX  = 7'h7f;
  localparam logic [IDX_W-1:0]  RAM_BASE_IDX = 7'h20;
  localparam logic [IDX_W-1:0]  CTRL_IDX     = 7'h0f;

  // ------------------------------------------------------------------
  // Masks, counts and reset values
  // ------------------------------------------------------------------
  localparam logic [BYTE_W-1:0] FULL_MASK    = 8'hff;
  localparam logic [BYTE_W-1:0] LOCK_MASK    = 8'h40;
  localparam logic [BYTE_W-1:0] BYTE_RST     = 8'h00;
  localparam logic [IDX_W-1:0]  IDX_RST      = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_LAST     = 3'h7;
  localparam logic [CNT_W-1:0]  CNT_FIRST    = 3'h0;
  localparam logic [CNT_W-1:0]  CNT_STEP     = 3'h1;

  // ------------------------------------------------------------------
  // Transfer phases
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_READ,
    PH_WRITE
  } rsp_phase_type;

endpackage : rsp_pkg

// ### rsp_store.sv
// Purpose : Clock and RAM byte store of the serial port, with write mask.
// Assumes : One write and one registered read per link clock edge.
// Notes   : Keeps a flopped copy of the write-lock bit of the control byte.

`timescale 1ns/100ps

module rsp_store
  #(
  parameter int unsigned DEPTH = rsp_pkg::MEM_DEPTH,
  parameter int unsigned AW    = rsp_pkg::IDX_W
  )
  (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_we,
  input  wire logic [AW-1:0]             i_waddr,
  input  wire logic [rsp_pkg::BYTE_W-1:0] i_wdata,
  input  wire logic [rsp_pkg::BYTE_W-1:0] i_wmask,
  input  wire logic [AW-1:0]             i_raddr,
  output logic      [rsp_pkg::BYTE_W-1:0] o_rdata,
  output logic                           o_lock
  );
  import rsp_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (DEPTH != (1 << AW))
  begin : g_bad_depth
    $error("rsp_store: depth must equal two to the address width");
  end

  logic [BYTE_W-1:0] mem [DEPTH];

  // Contents are undefined at power-up, as the clock chip's own are
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= (mem[i_waddr] & ~i_wmask) | (i_wdata & i_wmask);
    end
    o_rdata <= mem[i_raddr];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_lock <= 1'b0;
    end
    else if (i_we && (i_waddr == CTRL_IDX) && i_wmask[LOCK_BIT])
    begin
      o_lock <= i_wdata[LOCK_BIT];
    end
  end

endmodule : rsp_store

// ### rsp_serial_port.sv
// Purpose : Serial slave port of a clock/RAM chip, four-wire or shared line.
// Assumes : i_sclk is the master's shift clock, still while no frame runs.
// Notes   : Accepted writes are passed to the system clock domain.

`timescale 1ns/100ps

module rsp_serial_port
  (
  input  wire logic                       i_mclk,
  input  wire logic                       i_arst_n,
  input  wire logic                       i_sclk,
  input  wire logic                       i_ce,
  input  wire logic                       i_interface_select,
  input  wire logic                       i_serial_in,
  output logic                            o_serial_out,
  output logic                            o_serial_out_oe,
  output logic                            o_frame_active,
  output logic                            o_wr_strobe,
  output logic      [rsp_pkg::IDX_W-1:0]  o_wr_addr,
  output logic      [rsp_pkg::BYTE_W-1:0] o_wr_data
  );
  import rsp_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [BYTE_W-1:0] shift_in
    (
    input logic [BYTE_W-1:0] sh,
    input logic              bit_in,
    input logic              msb_first
    );
    logic [BYTE_W-1:0] res;
    res = msb_first ? {sh[BYTE_W-2:0], bit_in} : {bit_in, sh[BYTE_W-1:1]};
    return res;
  endfunction : shift_in

  function automatic logic [BYTE_W-1:0] next_ptr
    (
    input logic [BYTE_W-1:0] ptr
    );
    logic [BYTE_W-1:0] res;
    res = ptr + 8'h01;
    if (ptr[IDX_W-1:0] == CLK_TOP_IDX)
    begin
      res = {ptr[DIR_BIT], CLK_BASE_IDX};
    end
    else if (ptr[IDX_W-1:0] == RAM_TOP_IDX)
    begin
      res = {ptr[DIR_BIT], RAM_BASE_IDX};
    end
    return res;
  endfunction : next_ptr

  // ------------------------------------------------------------------
  // Frame configuration
  // ------------------------------------------------------------------
  typedef struct packed {
    logic four_wire;
    logic invert;
  } rsp_cfg_type;

  rsp_cfg_type cfg_q;

  // Transparent while chip enable is low, so the link clock already sits
  // at its idle level when the frame opens and no false edge appears.
  always_latch
  begin
    if (!i_ce)
    begin
      cfg_q.four_wire = i_interface_select;
      cfg_q.invert    = i_interface_select & ~i_sclk;
    end
  end

  logic link_clk;
  logic frame_rst_n;

  // Strobe edge becomes the rising link edge in four-wire mode
  assign link_clk    = i_sclk ^ cfg_q.invert;
  assign frame_rst_n = i_ce & i_arst_n;

  // ------------------------------------------------------------------
  // Capture side, strobe edge
  // ------------------------------------------------------------------
  typedef struct packed {
    rsp_phase_type     phase;
    logic [CNT_W-1:0]  cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] ptr;
  } rsp_link_type;

  rsp_link_type      link_q;
  rsp_link_type      link_d;
  logic [BYTE_W-1:0] byte_in;
  logic              mem_we;
  logic [BYTE_W-1:0] mem_wmask;
  logic [BYTE_W-1:0] mem_rdata;
  logic              lock;

  always_comb
  begin
    link_d    = link_q;
    mem_we    = 1'b0;
    mem_wmask = FULL_MASK;
    byte_in   = shift_in(link_q.shreg, i_serial_in, cfg_q.four_wire);
    link_d.shreg = byte_in;
    link_d.cnt   = link_q.cnt + CNT_STEP;
    if (link_q.cnt == CNT_LAST)
    begin
      unique case (link_q.phase)
        PH_ADDR:
        begin
          link_d.ptr   = byte_in;
          link_d.phase = byte_in[DIR_BIT] ? PH_WRITE : PH_READ;
        end
        PH_WRITE:
        begin
          if (!lock)
          begin
            mem_we = 1'b1;
          end
          else if (link_q.ptr[IDX_W-1:0] == CTRL_IDX)
          begin
            mem_we    = 1'b1;
            mem_wmask = LOCK_MASK;
          end
          link_d.ptr = next_ptr(link_q.ptr);
        end
        PH_READ:
        begin
          link_d.ptr = next_ptr(link_q.ptr);
        end
      endcase
    end
  end

  // Whole transfer state clears while chip enable is low
  always_ff @(posedge link_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      link_q.phase <= PH_ADDR;
      link_q.cnt   <= CNT_FIRST;
      link_q.shreg <= BYTE_RST;
      link_q.ptr   <= BYTE_RST;
    end
    else
    begin
      link_q <= link_d;
    end
  end

  // Read port follows the next pointer, so a byte is ready at the shift
  // edge right after the strobe edge that completed the address or byte.
  rsp_store
    #(
    .DEPTH (MEM_DEPTH),
    .AW    (IDX_W)
    )
  u_store
    (
    .i_clk    (link_clk),
    .i_arst_n (i_arst_n),
    .i_we     (mem_we),
    .i_waddr  (link_q.ptr[IDX_W-1:0]),
    .i_wdata  (byte_in),
    .i_wmask  (mem_wmask),
    .i_raddr  (link_d.ptr[IDX_W-1:0]),
    .o_rdata  (mem_rdata),
    .o_lock   (lock)
    );

  // ------------------------------------------------------------------
  // Write report, survives the end of the frame
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              tgl;
    logic [IDX_W-1:0]  addr;
    logic [BYTE_W-1:0] data;
  } rsp_keep_type;

  rsp_keep_type keep_q;
  rsp_keep_type keep_d;

  always_comb
  begin
    keep_d = keep_q;
    if (mem_we)
    begin
      keep_d.tgl  = ~keep_q.tgl;
      keep_d.addr = link_q.ptr[IDX_W-1:0];
      keep_d.data = byte_in;
    end
  end

  always_ff @(posedge link_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      keep_q.tgl  <= 1'b0;
      keep_q.addr <= IDX_RST;
      keep_q.data <= BYTE_RST;
    end
    else
    begin
      keep_q <= keep_d;
    end
  end

  // ------------------------------------------------------------------
  // Output side, shift edge
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              oe;
    logic              bit_out;
    logic [BYTE_W-1:0] shreg;
  } rsp_out_type;

  rsp_out_type out_q;
  rsp_out_type out_d;

  always_comb
  begin
    out_d = out_q;
    if ((link_q.phase == PH_READ) && (link_q.cnt == CNT_FIRST))
    begin
      out_d.oe = 1'b1;
      if (cfg_q.four_wire)
      begin
        out_d.bit_out = mem_rdata[BYTE_W-1];
        out_d.shreg   = {mem_rdata[BYTE_W-2:0], 1'b0};
      end
      else
      begin
        out_d.bit_out = mem_rdata[0];
        out_d.shreg   = {1'b0, mem_rdata[BYTE_W-1:1]};
      end
    end
    else if (out_q.oe)
    begin
      if (cfg_q.four_wire)
      begin
        out_d.bit_out = out_q.shreg[BYTE_W-1];
        out_d.shreg   = {out_q.shreg[BYTE_W-2:0], 1'b0};
      end
      else
      begin
        out_d.bit_out = out_q.shreg[0];
        out_d.shreg   = {1'b0, out_q.shreg[BYTE_W-1:1]};
      end
    end
  end

  always_ff @(negedge link_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      out_q.oe      <= 1'b0;
      out_q.bit_out <= 1'b0;
      out_q.shreg   <= BYTE_RST;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign o_serial_out    = out_q.bit_out;
  assign o_serial_out_oe = out_q.oe;

  // ------------------------------------------------------------------
  // System clock side
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              ce_s1;
    logic              ce_s2;
    logic              tg_s1;
    logic              tg_s2;
    logic              tg_s3;
    logic              strobe;
    logic [IDX_W-1:0]  addr;
    logic [BYTE_W-1:0] data;
  } rsp_sys_type;

  rsp_sys_type sys_q;
  rsp_sys_type sys_d;

  // Report words are stable for a whole byte time after the toggle moves,
  // far longer than the three system cycles the crossing takes.
  always_comb
  begin
    sys_d        = sys_q;
    sys_d.ce_s1  = i_ce;
    sys_d.ce_s2  = sys_q.ce_s1;
    sys_d.tg_s1  = keep_q.tgl;
    sys_d.tg_s2  = sys_q.tg_s1;
    sys_d.tg_s3  = sys_q.tg_s2;
    sys_d.strobe = sys_q.tg_s2 ^ sys_q.tg_s3;
    if (sys_q.tg_s2 ^ sys_q.tg_s3)
    begin
      sys_d.addr = keep_q.addr;
      sys_d.data = keep_q.data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sys_q.ce_s1  <= 1'b0;
      sys_q.ce_s2  <= 1'b0;
      sys_q.tg_s1  <= 1'b0;
      sys_q.tg_s2  <= 1'b0;
      sys_q.tg_s3  <= 1'b0;
      sys_q.strobe <= 1'b0;
      sys_q.addr   <= IDX_RST;
      sys_q.data   <= BYTE_RST;
    end
    else
    begin
      sys_q <= sys_d;
    end
  end

  assign o_frame_active = sys_q.ce_s2;
  assign o_wr_strobe    = sys_q.strobe;
  assign o_wr_addr      = sys_q.addr;
  assign o_wr_data      = sys_q.data;

endmodule : rsp_serial_port

// ### rsp_port_monitor.sv
// Purpose : Protocol checks on the serial port's own ports.
// Assumes : Link pins sampled on the system clock.
// Notes   : Bound to the port from the bench.
`timescale 1ns/100ps
module rsp_port_monitor
  (
  input wire logic                       i_mclk,
  input wire logic                       i_arst_n,
  input wire logic                       i_ce,
  input wire logic                       o_serial_out_oe,
  input wire logic                       o_frame_active,
  input wire logic                       o_wr_strobe,
  input wire logic [rsp_pkg::IDX_W-1:0]  o_wr_addr,
  input wire logic [rsp_pkg::BYTE_W-1:0] o_wr_data
  );
  logic [6:0] prev_q;
  logic       have_q;
  logic [6:0] nxt;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // ------------------------------------------------------------------
  // Last write index of this frame
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt = (prev_q == 7'h1f) ? 7'h00 : (prev_q == 7'h7f) ? 7'h20 : prev_q + 7'h01;
  end
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_q <= 7'h00;
      have_q <= 1'b0;
    end
    else if (!o_frame_active)
    begin
      have_q <= 1'b0;
    end
    else if (o_wr_strobe)
    begin
      prev_q <= o_wr_addr;
      have_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_oe_off; !i_ce |=> !o_serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_hold; o_serial_out_oe ##1 i_ce |-> o_serial_out_oe; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output released inside a frame");
  property p_oe_quiet; $rose(i_ce) |-> !o_serial_out_oe [*8]; endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("output driven during address byte");
  property p_fa_rise; $rose(i_ce) |-> ##[2:3] o_frame_active; endproperty
  a_fa_rise: assert property (p_fa_rise)
    else $error("frame flag late");
  property p_fa_off; !i_ce [*4] |-> !o_frame_active; endproperty
  a_fa_off: assert property (p_fa_off)
    else $error("frame flag stuck");
  property p_stb_one; o_wr_strobe |=> !o_wr_strobe; endproperty
  a_stb_one: assert property (p_stb_one)
    else $error("write strobe too long");
  property p_wr_no_out; o_wr_strobe |-> !o_serial_out_oe; endproperty
  a_wr_no_out: assert property (p_wr_no_out)
    else $error("write during a read frame");
  property p_wr_moves; $changed(o_wr_addr) || $changed(o_wr_data) |-> o_wr_strobe; endproperty
  a_wr_moves: assert property (p_wr_moves)
    else $error("write fields moved without strobe");
  property p_wrap; o_wr_strobe && have_q |-> o_wr_addr == nxt; endproperty
  a_wrap: assert property (p_wrap)
    else $error("write pointer step wrong");

  c_wrap: cover property (o_wr_strobe && have_q && o_wr_addr == 7'h20);
  c_read: cover property ($rose(o_serial_out_oe));
  c_end: cover property ($fell(o_frame_active));
endmodule : rsp_port_monitor

// ### rsp_master_model.sv
// Purpose : Link master driving clock, enable and data.
// Assumes : 48 ns link clock, toggled only inside frames.
// Notes   : Shared-line frames idle the clock low.
`timescale 1ns/100ps
module rsp_master_model
  (
  input  wire logic i_sdata,
  input  wire logic i_oe,
  output logic      o_sclk,
  output logic      o_ce,
  output logic      o_sel,
  output logic      o_mosi
  );
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];

  initial
  begin
    o_sclk = 1'b0;
    o_ce   = 1'b0;
    o_sel  = 1'b1;
    o_mosi = 1'b0;
  end

  // ------------------------------------------------------------------
  // Frame: address byte, then n data bytes
  // ------------------------------------------------------------------
  task automatic frame(input logic fw, input logic pol, input logic [7:0] a, input int n);
    logic [7:0] tx;
    int         b;
    int         s;
    o_sel  = fw;
    o_sclk = pol;
    #100 o_ce = 1'b1;
    #100;
    for (b = 0; b < 8 * (n + 1); b++)
    begin
      s  = b - 8;
      tx = (b < 8) ? a : wbuf[s / 8];
      // Junk on the line during reads: the port must ignore it
      o_mosi = (b < 8 || a[7]) ? tx[fw ? 7 - b % 8 : b % 8] : ~o_mosi;
      #12 o_sclk = ~pol;
      if (!fw && s >= 0) rbuf[s / 8][s % 8] = i_oe ? i_sdata : 1'bx;
      #24 o_sclk = pol;
      if (fw && s >= 0) rbuf[s / 8][7 - s % 8] = i_oe ? i_sdata : 1'bx;
      #12;
    end
    #250 o_ce = 1'b0;
    #250;
  endtask : frame
endmodule : rsp_master_model

// ### tb_rsp_serial_port.sv
// Purpose : Self-checking bench of the serial slave port.
// Assumes : Store contents unknown until written.
// Notes   : Expected bytes come from a shadow copy kept here.
`timescale 1ns/100ps
module tb_rsp_serial_port;
  import rsp_pkg::*;
  logic              mclk, arst_n, sclk, ce, sel, mosi, sin, sout, oe, fa, wstb, lock;
  logic [IDX_W-1:0]  waddr;
  logic [BYTE_W-1:0] wdata;
  logic [BYTE_W-1:0] mem [MEM_DEPTH];
  logic [14:0]       wq [$];
  int                n_fail;
  int                compares;

  rsp_serial_port uut (.i_mclk(mclk), .i_arst_n(arst_n), .i_sclk(sclk), .i_ce(ce),
    .i_interface_select(sel), .i_serial_in(sin), .o_serial_out(sout), .o_serial_out_oe(oe),
    .o_frame_active(fa), .o_wr_strobe(wstb), .o_wr_addr(waddr), .o_wr_data(wdata));
  rsp_master_model u_master (.i_sdata(sout), .i_oe(oe), .o_sclk(sclk), .o_ce(ce),
    .o_sel(sel), .o_mosi(mosi));
  assign sin = (sel || !oe) ? mosi : sout;

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Mid-cycle sampling keeps clear of the strobe's own edge
  always @(negedge mclk) if (wstb === 1'b1) wq.push_back({waddr, wdata});

  function automatic logic [6:0] nxt(input logic [6:0] i);
    return (i == CLK_TOP_IDX) ? CLK_BASE_IDX : (i == RAM_TOP_IDX) ? RAM_BASE_IDX : i + 7'h01;
  endfunction : nxt

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrx(input logic fw, input logic pol, input logic [7:0] a, input int n,
                     input logic [7:0] seed);
    logic [6:0] i;
    int         k;
    for (k = 0; k < n; k++) u_master.wbuf[k] = seed + 8'h3b * 8'(k);
    u_master.frame(fw, pol, a, n);
    i = a[6:0];
    for (k = 0; k < n; k++)
    begin
      if (!lock || i == CTRL_IDX)
      begin
        chk(wq.size() ? wq.pop_front() : 15'bx, {i, u_master.wbuf[k]});
        if (lock) mem[i][LOCK_BIT] = u_master.wbuf[k][LOCK_BIT];
        else mem[i] = u_master.wbuf[k];
        if (i == CTRL_IDX) lock = u_master.wbuf[k][LOCK_BIT];
      end
      i = nxt(i);
    end
    chk(15'(wq.size()), 15'h0);
  endtask : wrx

  task automatic rdx(input logic fw, input logic pol, input logic [7:0] a, input int n);
    logic [6:0] i;
    int         k;
    u_master.frame(fw, pol, a, n);
    i = a[6:0];
    for (k = 0; k < n; k++)
    begin
      chk({7'h0, u_master.rbuf[k]}, {7'h0, mem[i]});
      i = nxt(i);
    end
    chk(15'(wq.size()), 15'h0);
  endtask : rdx

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_four_wire;
    wrx(1'b1, 1'b0, 8'h9e, 4, 8'h5a);
    rdx(1'b1, 1'b1, 8'h1e, 4);
    $display("test four_wire ended");
  endtask : t_four_wire

  task automatic t_shared_line;
    wrx(1'b0, 1'b0, 8'hfe, 3, 8'hc3);
    rdx(1'b0, 1'b0, 8'h7e, 3);
    $display("test shared_line ended");
  endtask : t_shared_line

  task automatic t_write_lock;
    wrx(1'b1, 1'b0, 8'h85, 1, 8'h21);
    wrx(1'b1, 1'b0, 8'h8f, 1, 8'h40);
    wrx(1'b1, 1'b1, 8'h85, 1, 8'ha5);
    rdx(1'b1, 1'b0, 8'h05, 1);
    wrx(1'b0, 1'b0, 8'h8f, 1, 8'h07);
    rdx(1'b0, 1'b0, 8'h0f, 1);
    wrx(1'b1, 1'b1, 8'h85, 1, 8'h3c);
    rdx(1'b1, 1'b1, 8'h05, 1);
    $display("test write_lock ended");
  endtask : t_write_lock

  task automatic stop_test;
    $display("counts compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    arst_n   = 1'b0;
    lock     = 1'b0;
    n_fail   = 0;
    compares = 0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_four_wire;
    t_shared_line;
    t_write_lock;
    stop_test;
  end

  // About 12 frames of under 3 us each; ample margin
  initial
  begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule : tb_rsp_serial_port

bind rsp_serial_port rsp_port_monitor u_mon (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce),
  .o_serial_out_oe(o_serial_out_oe), .o_frame_active(o_frame_active), .o_wr_strobe(o_wr_strobe),
  .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
